/* File: hdl/smcm_defs.vh */
`ifndef SMCM_DEFS_VH
`define SMCM_DEFS_VH
`define SMCM_OFS_SETUP     2'h0
`define SMCM_OFS_PULSE     2'h1
`define SMCM_OFS_CYCLE     2'h2
`define SMCM_OFS_MODE      2'h3
`define SMCM_STRIDE_LSB    4
`define SMCM_RST_SETUP     32'h01010101
`define SMCM_RST_PULSE     32'h01010101
`define SMCM_RST_CYCLE     32'h00030003
`define SMCM_RST_MODE      32'h10001000
`define SMCM_MASK_SETUP    32'h3f3f3f3f
`define SMCM_MASK_PULSE    32'h7f7f7f7f
`define SMCM_MASK_CYCLE    32'h01ff01ff
`define SMCM_MASK_MODE     32'h311f3133
`define SMCM_F_WR          0
`define SMCM_F_CSWR        8
`define SMCM_F_RD          16
`define SMCM_F_CSRD        24
`define SMCM_F_RD_MODE     0
`define SMCM_F_WR_MODE     1
`define SMCM_F_WAIT        4
`define SMCM_F_BAT         8
`define SMCM_F_DBW         12
`define SMCM_F_TDF         16
`define SMCM_F_FLOAT_OPTIMIZE    20
`define SMCM_F_PAGE_READ_ENABLE        24
`define SMCM_F_PS          28
`define SMCM_WAIT_OFF      2'h0
`define SMCM_WAIT_FROZEN   2'h2
`define SMCM_WAIT_READY    2'h3
`define SMCM_DBW_8         2'h0
`define SMCM_DBW_16        2'h1
`define SMCM_PS_4          2'h0
`define SMCM_PS_8          2'h1
`define SMCM_PS_16         2'h2
`define SMCM_CYC_UNIT      10'h100
`define SMCM_SETUP_UNIT    10'h080
`define SMCM_PULSE_UNIT    10'h100
`endif

/* File: hdl/smcm_cfg_ram.v */
module smcm_cfg_ram #(
	parameter W  = 32,
	parameter AW = 5
) (
	input  wire          clk,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [W-1:0]  wdata,
	input  wire [AW-1:0] raddr,
	output reg  [W-1:0]  rdata
);
	reg [W-1:0] mem [0:(1<<AW)-1];

	// A read of the word being written returns the new value.
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (we && (waddr == raddr)) begin
			rdata <= wdata;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // smcm_cfg_ram

/* File: hdl/smcm_timing.v */
`include "smcm_defs.vh"
module smcm_timing (
	input  wire [31:0] setup_word,
	input  wire [31:0] pulse_word,
	input  wire [31:0] cycle_word,
	input  wire [31:0] mode_word,
	input  wire        is_write,
	input  wire        page_read,
	input  wire        page_hit,
	output reg  [9:0]  strb_setup,
	output reg  [9:0]  strb_pulse,
	output reg  [9:0]  sel_setup,
	output reg  [9:0]  sel_pulse,
	output reg  [9:0]  cyc_len,
	output reg  [9:0]  ctl_setup,
	output reg  [9:0]  ctl_pulse
);
	function [9:0] setup_len;
		input [5:0] f;
		setup_len = (f[5] ? `SMCM_SETUP_UNIT : 10'h000) + {5'h00, f[4:0]};
	endfunction

	function [9:0] pulse_len;
		input [6:0] f;
		pulse_len = (f[6] ? `SMCM_PULSE_UNIT : 10'h000) + {4'h0, f[5:0]};
	endfunction

	function [9:0] cycle_len;
		input [8:0] f;
		cycle_len = ({8'h00, f[8:7]} * `SMCM_CYC_UNIT) + {3'h0, f[6:0]};
	endfunction

	reg [9:0] len;
	reg       strb_ctl;

	// Hold is what remains of the cycle after setup and pulse. see RULE3
	always @* begin
		len = 10'h000;
		strb_ctl = 1'b0;
		if (is_write) begin
			strb_setup = setup_len(setup_word[`SMCM_F_WR+5:`SMCM_F_WR]);
			strb_pulse = pulse_len(pulse_word[`SMCM_F_WR+6:`SMCM_F_WR]);
			sel_setup  = setup_len(setup_word[`SMCM_F_CSWR+5:`SMCM_F_CSWR]);
			sel_pulse  = pulse_len(pulse_word[`SMCM_F_CSWR+6:`SMCM_F_CSWR]);
			len        = cycle_len(cycle_word[`SMCM_F_WR+8:`SMCM_F_WR]); // see RULE1
			strb_ctl   = mode_word[`SMCM_F_WR_MODE]; // see RULE5
		end else if (page_read) begin
			strb_setup = 10'h000;
			sel_setup  = 10'h000;
			strb_pulse = page_hit ? pulse_len(pulse_word[`SMCM_F_RD+6:`SMCM_F_RD]) :
				pulse_len(pulse_word[`SMCM_F_CSRD+6:`SMCM_F_CSRD]);
			sel_pulse  = strb_pulse;
			len        = strb_pulse;
		end else begin
			strb_setup = setup_len(setup_word[`SMCM_F_RD+5:`SMCM_F_RD]);
			strb_pulse = pulse_len(pulse_word[`SMCM_F_RD+6:`SMCM_F_RD]);
			sel_setup  = setup_len(setup_word[`SMCM_F_CSRD+5:`SMCM_F_CSRD]);
			sel_pulse  = pulse_len(pulse_word[`SMCM_F_CSRD+6:`SMCM_F_CSRD]);
			len        = cycle_len(cycle_word[`SMCM_F_RD+8:`SMCM_F_RD]); // see RULE2
			strb_ctl   = mode_word[`SMCM_F_RD_MODE]; // see RULE4
		end
		cyc_len   = (len == 10'h000) ? 10'h001 : len;
		ctl_setup = strb_ctl ? strb_setup : sel_setup;
		ctl_pulse = strb_ctl ? strb_pulse : sel_pulse;
	end
endmodule // smcm_timing

/* File: hdl/smcm_top.v */
// How it works
// RULE1: write cycle length from write-cycle field.
// RULE2: read cycle length from read-cycle field.
// RULE3: hold fills cycle after setup and pulse.
// RULE4: read-mode bit picks read strobe or select.
// RULE5: write-mode bit picks write strobe or select.
// RULE6: optimized float waits after controlling setup phase.
// RULE7: optimize overlaps float with next setup.
// RULE8: wait input sampled only during controlling pulse.
// RULE9: software programs hold when wait is used.
// RULE10: wait field: off, reserved, frozen, ready.
// RULE11: frozen mode halts cycle, resumes same point.
// RULE12: ready mode extends access at pulse end.
// RULE13: byte-write kind uses per-byte write strobes.
// RULE14: byte-select kind uses write strobe, selects.
// RULE15: byte kind ignored on an 8-bit bus.
// RULE16: width field: 8, 16, 32 bits, reserved.
// RULE17: bus held for float count plus one.
// RULE18: page enable gives page-mode burst reads.
// RULE19: page size field: 4, 8, 16, 32 bytes.
// RULE20: four registers per chip select.
// RULE21: settings take effect on mode register write.
// RULE22: reserved encodings give undefined access behaviour.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`include "smcm_defs.vh"
module smcm_top #(
	parameter NUM_CS = 8,
	parameter CSW    = 3,
	parameter ADDR_W = 26
) (
	input  wire              hclk,
	input  wire              hresetn,
	input  wire              hsel,
	input  wire [31:0]       haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire [31:0]       hwdata,
	input  wire              hready,
	output reg               hreadyout,
	output reg               hresp,
	output reg  [31:0]       hrdata,
	input  wire              acc_req,
	input  wire [CSW-1:0]    acc_cs,
	input  wire              acc_write,
	input  wire [ADDR_W-1:0] acc_addr,
	input  wire [3:0]        acc_be,
	input  wire [31:0]       acc_wdata,
	output reg               acc_done,
	output reg  [31:0]       acc_rdata,
	output reg  [NUM_CS-1:0] chip_select_n,
	output reg               read_strobe_n,
	output reg               write_strobe_n,
	output reg  [3:0]        byte_write_strobe_n,
	output reg  [3:0]        byte_select_n,
	output reg  [ADDR_W-1:0] ext_addr,
	output reg  [31:0]       ext_data_out,
	output reg  [3:0]        ext_data_oe,
	input  wire [31:0]       ext_data_in,
	input  wire              external_wait_n,
	output reg               ext_bus_busy
);
	localparam RAW = CSW + 2;
	localparam [RAW-1:0] LAST_IDX = {RAW{1'b1}};
	localparam [27:0]    CS_LIMIT = NUM_CS;
	localparam [3:0] B_INIT = 4'h1;
	localparam [3:0] B_IDLE = 4'h2;
	localparam [3:0] B_RDW  = 4'h4;
	localparam [3:0] B_CPY  = 4'h8;
	localparam [2:0] E_IDLE = 3'h1;
	localparam [2:0] E_LOAD = 3'h2;
	localparam [2:0] E_RUN  = 3'h4;

	function [31:0] reset_word;
		input [1:0] sel;
		case (sel)
			`SMCM_OFS_SETUP: reset_word = `SMCM_RST_SETUP;
			`SMCM_OFS_PULSE: reset_word = `SMCM_RST_PULSE;
			`SMCM_OFS_CYCLE: reset_word = `SMCM_RST_CYCLE;
			default:         reset_word = `SMCM_RST_MODE;
		endcase
	endfunction

	function [31:0] field_mask;
		input [1:0] sel;
		case (sel)
			`SMCM_OFS_SETUP: field_mask = `SMCM_MASK_SETUP;
			`SMCM_OFS_PULSE: field_mask = `SMCM_MASK_PULSE;
			`SMCM_OFS_CYCLE: field_mask = `SMCM_MASK_CYCLE;
			default:         field_mask = `SMCM_MASK_MODE;
		endcase
	endfunction

	// Reserved width code behaves as a 32-bit bus. see RULE22
	function [3:0] lane_mask;
		input [1:0] bus_width_sel;
		case (bus_width_sel)
			`SMCM_DBW_8:  lane_mask = 4'h1; // see RULE16
			`SMCM_DBW_16: lane_mask = 4'h3;
			default:      lane_mask = 4'hf;
		endcase
	endfunction

	function [ADDR_W-1:0] page_ignore;
		input [1:0] ps;
		case (ps)
			`SMCM_PS_4:  page_ignore = {{(ADDR_W-2){1'b0}}, 2'h3}; // see RULE19
			`SMCM_PS_8:  page_ignore = {{(ADDR_W-3){1'b0}}, 3'h7};
			`SMCM_PS_16: page_ignore = {{(ADDR_W-4){1'b0}}, 4'hf};
			default:     page_ignore = {{(ADDR_W-5){1'b0}}, 5'h1f};
		endcase
	endfunction

	reg  [3:0]        bst_q;
	reg  [RAW-1:0]    idx_q;
	reg  [2:0]        cpy_cnt_q;
	reg  [CSW-1:0]    cpy_cs_q;
	reg               wr_pend_q;
	reg  [RAW-1:0]    ph_idx_q;
	reg               ph_unmapped_q;
	reg  [2:0]        est_q;
	reg  [2:0]        ld_cnt_q;
	reg  [31:0]       cfg_setup_q;
	reg  [31:0]       cfg_pulse_q;
	reg  [31:0]       cfg_cycle_q;
	reg  [31:0]       cfg_mode_q;
	reg  [CSW-1:0]    cs_q;
	reg               wr_q;
	reg  [3:0]        be_q;
	reg  [9:0]        cyc_q;
	reg  [4:0]        float_cnt_q;
	reg  [CSW-1:0]    float_cs_q;
	reg               page_valid_q;
	reg  [CSW-1:0]    page_cs_q;
	reg  [ADDR_W-1:0] page_tag_q;
	reg               page_hit_q;
	wire [31:0]       a_rdata;
	wire [31:0]       b_rdata;
	wire [9:0]        strb_setup;
	wire [9:0]        strb_pulse;
	wire [9:0]        sel_setup;
	wire [9:0]        sel_pulse;
	wire [9:0]        cyc_len;
	wire [9:0]        ctl_setup;
	wire [9:0]        ctl_pulse;

	wire             accept   = hsel && htrans[1] && hready;
	wire             mapped   = (haddr[31:4] < CS_LIMIT);
	wire [RAW-1:0]   hidx     = {haddr[`SMCM_STRIDE_LSB+CSW-1:`SMCM_STRIDE_LSB], haddr[3:2]};
	wire             init     = bst_q[0];
	wire             cpy_wr   = bst_q[3] && (cpy_cnt_q >= 3'h2);
	wire [1:0]       cpy_rsel = cpy_cnt_q[1:0] - 2'h1;
	wire [1:0]       cpy_wsel = cpy_cnt_q[1:0] - 2'h2;
	wire             a_we     = init || wr_pend_q;
	wire [RAW-1:0]   a_waddr  = init ? idx_q : ph_idx_q;
	wire [31:0]      a_wdata  = init ? reset_word(idx_q[1:0]) : (hwdata & field_mask(ph_idx_q[1:0]));
	wire [RAW-1:0]   a_raddr  = bst_q[3] ? {cpy_cs_q, cpy_rsel} : hidx;
	wire             b_we     = init || cpy_wr;
	wire [RAW-1:0]   b_waddr  = init ? idx_q : {cpy_cs_q, cpy_wsel};
	wire [31:0]      b_wdata  = init ? reset_word(idx_q[1:0]) : a_rdata;
	wire [RAW-1:0]   b_raddr  = {cs_q, ld_cnt_q[1:0]};

	// Software view of the four registers of every chip select. see RULE20
	smcm_cfg_ram #(.W(32), .AW(RAW)) u_view_ram (
		.clk   (hclk),
		.we    (a_we),
		.waddr (a_waddr),
		.wdata (a_wdata),
		.raddr (a_raddr),
		.rdata (a_rdata)
	);

	// Settings in force; filled with reset values at init, then refreshed only by a mode register write. see RULE21
	smcm_cfg_ram #(.W(32), .AW(RAW)) u_live_ram (
		.clk   (hclk),
		.we    (b_we),
		.waddr (b_waddr),
		.wdata (b_wdata),
		.raddr (b_raddr),
		.rdata (b_rdata)
	);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bst_q         <= B_INIT;
			idx_q         <= {RAW{1'b0}};
			cpy_cnt_q     <= 3'h0;
			cpy_cs_q      <= {CSW{1'b0}};
			wr_pend_q     <= 1'b0;
			ph_idx_q      <= {RAW{1'b0}};
			ph_unmapped_q <= 1'b0;
			hreadyout     <= 1'b0;
			hresp         <= 1'b0;
			hrdata        <= 32'h00000000;
		end else begin
			hresp     <= 1'b0;
			wr_pend_q <= 1'b0;
			case (bst_q)
				B_INIT: begin
					idx_q <= idx_q + {{(RAW-1){1'b0}}, 1'b1};
					if (idx_q == LAST_IDX) begin
						bst_q     <= B_IDLE;
						hreadyout <= 1'b1;
					end
				end
				B_IDLE: begin
					if (accept) begin
						ph_idx_q      <= hidx;
						ph_unmapped_q <= !mapped;
						wr_pend_q     <= hwrite && mapped;
						if (!hwrite) begin
							hreadyout <= 1'b0;
							bst_q     <= B_RDW;
						end else if (mapped && (haddr[3:2] == `SMCM_OFS_MODE)) begin
							hreadyout <= 1'b0;
							cpy_cnt_q <= 3'h0;
							cpy_cs_q  <= hidx[RAW-1:2];
							bst_q     <= B_CPY; // see RULE21
						end
					end
				end
				B_RDW: begin
					hrdata    <= ph_unmapped_q ? 32'h00000000 : a_rdata;
					hreadyout <= 1'b1;
					bst_q     <= B_IDLE;
				end
				B_CPY: begin
					cpy_cnt_q <= cpy_cnt_q + 3'h1;
					if (cpy_cnt_q == 3'h5) begin
						hreadyout <= 1'b1;
						bst_q     <= B_IDLE;
					end
				end
				default: begin
					bst_q <= B_INIT;
				end
			endcase
		end
	end

	wire       page_rd   = cfg_mode_q[`SMCM_F_PAGE_READ_ENABLE] && !wr_q; // see RULE18

	smcm_timing u_timing (
		.setup_word (cfg_setup_q),
		.pulse_word (cfg_pulse_q),
		.cycle_word (cfg_cycle_q),
		.mode_word  (cfg_mode_q),
		.is_write   (wr_q),
		.page_read  (page_rd),
		.page_hit   (page_hit_q),
		.strb_setup (strb_setup),
		.strb_pulse (strb_pulse),
		.sel_setup  (sel_setup),
		.sel_pulse  (sel_pulse),
		.cyc_len    (cyc_len),
		.ctl_setup  (ctl_setup),
		.ctl_pulse  (ctl_pulse)
	);

	wire [1:0] wait_mode = cfg_mode_q[`SMCM_F_WAIT+1:`SMCM_F_WAIT]; // see RULE10
	wire [1:0] bus_width_sel       = cfg_mode_q[`SMCM_F_DBW+1:`SMCM_F_DBW];
	wire [3:0] lanes     = lane_mask(bus_width_sel);
	wire [31:0] lane_bits = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
	wire       float_opt = cfg_mode_q[`SMCM_F_FLOAT_OPTIMIZE];
	wire       bat_eff   = cfg_mode_q[`SMCM_F_BAT] && (bus_width_sel != `SMCM_DBW_8); // see RULE15
	wire [9:0] ctl_end   = ctl_setup + ctl_pulse;
	wire       in_sel    = (cyc_q >= sel_setup) && (cyc_q < sel_setup + sel_pulse);
	wire       in_strb   = (cyc_q >= strb_setup) && (cyc_q < strb_setup + strb_pulse);
	wire       in_ctl    = (cyc_q >= ctl_setup) && (cyc_q < ctl_end);
	wire       ctl_last  = (cyc_q + 10'h001 == ctl_end);
	wire       foreign   = (float_cnt_q != 5'h00) && (float_cs_q != cs_q);
	wire       run       = est_q[2];
	wire       hold_off  = foreign && !float_opt; // see RULE7
	wire       float_stl = foreign && float_opt && (cyc_q == ctl_setup); // see RULE6
	wire       frz_stl   = (wait_mode == `SMCM_WAIT_FROZEN) && in_ctl && !external_wait_n; // see RULE11
	wire       rdy_stl   = (wait_mode == `SMCM_WAIT_READY) && ctl_last && !external_wait_n; // see RULE12
	wire       stall     = hold_off || float_stl || frz_stl || rdy_stl; // see RULE8
	wire       last      = (cyc_q + 10'h001 == cyc_len);
	wire       active    = run && !hold_off;
	wire [ADDR_W-1:0] pg_ign = page_ignore(b_rdata[`SMCM_F_PS+1:`SMCM_F_PS]);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			est_q        <= E_IDLE;
			ld_cnt_q     <= 3'h0;
			cfg_setup_q  <= `SMCM_RST_SETUP;
			cfg_pulse_q  <= `SMCM_RST_PULSE;
			cfg_cycle_q  <= `SMCM_RST_CYCLE;
			cfg_mode_q   <= `SMCM_RST_MODE;
			cs_q         <= {CSW{1'b0}};
			wr_q         <= 1'b0;
			be_q         <= 4'h0;
			cyc_q        <= 10'h000;
			float_cnt_q  <= 5'h00;
			float_cs_q   <= {CSW{1'b0}};
			page_valid_q <= 1'b0;
			page_cs_q    <= {CSW{1'b0}};
			page_tag_q   <= {ADDR_W{1'b0}};
			page_hit_q   <= 1'b0;
			acc_done     <= 1'b0;
			acc_rdata    <= 32'h00000000;
			ext_addr     <= {ADDR_W{1'b0}};
			ext_data_out <= 32'h00000000;
			ext_bus_busy <= 1'b0;
		end else begin
			acc_done <= 1'b0;
			if (float_cnt_q != 5'h00) begin
				float_cnt_q <= float_cnt_q - 5'h01;
			end
			case (est_q)
				E_IDLE: begin
					if (acc_req && !acc_done && !init) begin
						cs_q         <= acc_cs;
						wr_q         <= acc_write;
						be_q         <= acc_be;
						ext_addr     <= acc_addr;
						ext_data_out <= acc_wdata;
						ld_cnt_q     <= 3'h0;
						est_q        <= E_LOAD;
					end
				end
				E_LOAD: begin
					ld_cnt_q <= ld_cnt_q + 3'h1;
					case (ld_cnt_q)
						3'h1: cfg_setup_q <= b_rdata;
						3'h2: cfg_pulse_q <= b_rdata;
						3'h3: cfg_cycle_q <= b_rdata;
						3'h4: cfg_mode_q  <= b_rdata;
						default: cfg_mode_q <= cfg_mode_q;
					endcase
					if (ld_cnt_q == 3'h4) begin
						page_hit_q <= page_valid_q && (page_cs_q == cs_q) &&
							(((page_tag_q ^ ext_addr) & ~pg_ign) == {ADDR_W{1'b0}});
						cyc_q      <= 10'h000;
						est_q      <= E_RUN;
					end
				end
				E_RUN: begin
					if (!stall && ctl_last && !wr_q) begin
						acc_rdata <= ext_data_in & lane_bits;
					end
					if (!stall) begin
						if (last) begin
							acc_done     <= 1'b1;
							est_q        <= E_IDLE;
							page_valid_q <= page_rd;
							page_cs_q    <= cs_q;
							page_tag_q   <= ext_addr;
							if (!wr_q) begin
								float_cnt_q <= {1'b0, cfg_mode_q[`SMCM_F_TDF+3:`SMCM_F_TDF]} + 5'h01; // see RULE17
								float_cs_q  <= cs_q;
							end
						end else begin
							cyc_q <= cyc_q + 10'h001;
						end
					end
				end
				default: begin
					est_q <= E_IDLE;
				end
			endcase
			ext_bus_busy <= (float_cnt_q > 5'h01) || (run && !stall && last && !wr_q);
		end
	end

	// Strobes and lanes follow the counter one cycle later.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chip_select_n       <= {NUM_CS{1'b1}};
			read_strobe_n       <= 1'b1;
			write_strobe_n      <= 1'b1;
			byte_write_strobe_n <= 4'hf;
			byte_select_n       <= 4'hf;
			ext_data_oe         <= 4'h0;
		end else begin
			chip_select_n       <= {NUM_CS{1'b1}};
			read_strobe_n       <= 1'b1;
			write_strobe_n      <= 1'b1;
			byte_write_strobe_n <= 4'hf;
			byte_select_n       <= 4'hf;
			ext_data_oe         <= 4'h0;
			if (active) begin
				chip_select_n[cs_q] <= !in_sel;
				if (wr_q) begin
					ext_data_oe <= in_sel ? lane_mask(bus_width_sel) : 4'h0;
					if (bat_eff) begin
						byte_write_strobe_n <= ~(be_q & {4{in_strb}}); // see RULE13
					end else begin
						write_strobe_n <= !in_strb; // see RULE14
						if (bus_width_sel != `SMCM_DBW_8) begin
							byte_select_n <= ~(be_q & {4{in_sel}});
						end
					end
				end else begin
					read_strobe_n <= !in_strb;
					if (!bat_eff && (bus_width_sel != `SMCM_DBW_8)) begin
						byte_select_n <= ~(be_q & {4{in_sel}}); // see RULE14
					end
				end
			end
		end
	end
endmodule // smcm_top

/* File: test/smcm_top_asserts.sv */
module smcm_top_asserts #(
	parameter NUM_CS = 8,
	parameter CSW    = 3,
	parameter ADDR_W = 26
) (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              acc_req,
	input wire logic              acc_done,
	input wire logic [NUM_CS-1:0] chip_select_n,
	input wire logic              read_strobe_n,
	input wire logic              write_strobe_n,
	input wire logic [3:0]        byte_write_strobe_n,
	input wire logic [3:0]        byte_select_n,
	input wire logic [3:0]        ext_data_oe,
	input wire logic              ext_bus_busy
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Register transfers that the block accepts inside its mapped window.
	sequence s_rd_taken;
		hsel && htrans[1] && hready && !hwrite && (haddr < NUM_CS * 16);
	endsequence
	sequence s_mode_taken;
		hsel && htrans[1] && hready && hwrite && (haddr[3:2] == 2'h3) && (haddr < NUM_CS * 16);
	endsequence
	sequence s_one_wait;
		##1 !hreadyout ##1 hreadyout;
	endsequence
	sequence s_mode_copy;
		##1 !hreadyout [*6] ##1 hreadyout;
	endsequence

	a_read_wait: assert property (s_rd_taken |-> s_one_wait)
		else $error("register read did not answer after one wait state");
	a_mode_apply: assert property (s_mode_taken |-> s_mode_copy)
		else $error("mode write did not copy settings in six cycles");
	a_plain_write: assert property (hsel && htrans[1] && hready && hwrite && (haddr[3:2] != 2'h3)
		&& (haddr < NUM_CS * 16) |=> hreadyout)
		else $error("plain register write was stalled");
	a_done_pulse: assert property (acc_done |=> !acc_done)
		else $error("access done lasted more than one cycle");
	a_done_min: assert property ($rose(acc_req) |-> !acc_done [*6])
		else $error("access finished too early");
	a_rd_wr_excl: assert property (read_strobe_n || write_strobe_n)
		else $error("read and write strobes low together");
	a_one_select: assert property ($onehot0(~chip_select_n))
		else $error("more than one chip select active");
	a_byte_kinds: assert property ((&byte_write_strobe_n) || (&byte_select_n))
		else $error("byte write strobes and byte selects active together");
	a_oe_no_read: assert property ((|ext_data_oe) |-> read_strobe_n)
		else $error("data driven while the read strobe is low");
	a_busy_bounded: assert property ($rose(ext_bus_busy) |-> ##[1:16] !ext_bus_busy)
		else $error("bus busy outlasted the longest float time");
endmodule // smcm_top_asserts

bind smcm_top smcm_top_asserts #(.NUM_CS(NUM_CS), .CSW(CSW), .ADDR_W(ADDR_W)) smcm_top_asserts_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .acc_req(acc_req), .acc_done(acc_done),
	.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.byte_write_strobe_n(byte_write_strobe_n), .byte_select_n(byte_select_n),
	.ext_data_oe(ext_data_oe), .ext_bus_busy(ext_bus_busy));

/* File: test/smcm_mem_model.sv */
module smcm_mem_model (
	input  wire logic        hclk,
	input  wire logic [7:0]  chip_select_n,
	input  wire logic        read_strobe_n,
	input  wire logic        write_strobe_n,
	input  wire logic [31:0] ext_data_out,
	input  wire logic [3:0]  ext_data_oe,
	input  wire logic [31:0] rd_word,
	input  wire logic [3:0]  stall_len,
	output wire logic [31:0] ext_data_in,
	output wire logic        external_wait_n,
	output logic      [31:0] wr_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] last_q  = 32'h0;
	logic [3:0]  stall_q = 4'h0;
	logic        prev_q  = 1'b1;
	wire         drive   = !read_strobe_n && !(&chip_select_n);
	wire         strb    = read_strobe_n & write_strobe_n;

	// A released data bus shows the inverse of what was last driven.
	assign ext_data_in     = drive ? rd_word : ~last_q;
	assign external_wait_n = (stall_q == 4'h0);
	initial wr_seen = 32'h0;

	// The wait line is pulled low for stall_len cycles after a strobe falls.
	always @(posedge hclk) begin
		prev_q <= strb;
		if (drive)
			last_q <= rd_word;
		if (ext_data_oe == 4'hf)
			wr_seen <= ext_data_out;
		if (prev_q && !strb)
			stall_q <= stall_len;
		else if (stall_q != 4'h0)
			stall_q <= stall_q - 4'h1;
	end
endmodule // smcm_mem_model

/* File: test/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, acc_req = 0, acc_write = 0, ws_low;
	logic [31:0] haddr = 0, hwdata = 0, acc_wdata = 0, q, rd_word = 32'h5a3c96e1;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2, acc_cs = 0;
	logic [25:0] acc_addr = 0;
	logic [3:0]  acc_be = 4'hf, stall_len = 0, bws_low, bs_low;
	wire         hready, hreadyout, hresp, acc_done, read_strobe_n, write_strobe_n, external_wait_n, ext_bus_busy;
	wire  [31:0] hrdata, acc_rdata, ext_data_out, ext_data_in, wr_seen;
	wire  [7:0]  chip_select_n;
	wire  [3:0]  bws_n, bs_n, oe;
	wire  [25:0] ext_addr;
	int          err_total = 0, n_tests = 0, cyc = 0, busy_n = 0, lat, la, lb;
	logic [31:0] rstv[4] = '{32'h01010101, 32'h01010101, 32'h00030003, 32'h10001000};
	logic [31:0] mskv[4] = '{32'h3f3f3f3f, 32'h7f7f7f7f, 32'h01ff01ff, 32'h311f3133};
	logic [31:0] wmsk[3] = '{32'h000000ff, 32'h0000ffff, 32'hffffffff};
	int          tdfs[3] = '{0, 3, 15};

	assign hready = hreadyout;
	always #12.5 hclk = ~hclk;

	smcm_top smcm_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.acc_req(acc_req), .acc_cs(acc_cs), .acc_write(acc_write), .acc_addr(acc_addr), .acc_be(acc_be),
		.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata), .chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .byte_write_strobe_n(bws_n),
		.byte_select_n(bs_n), .ext_addr(ext_addr), .ext_data_out(ext_data_out), .ext_data_oe(oe),
		.ext_data_in(ext_data_in), .external_wait_n(external_wait_n), .ext_bus_busy(ext_bus_busy));

	smcm_mem_model smcm_mem_model_inst (
		.hclk(hclk), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n), .ext_data_out(ext_data_out), .ext_data_oe(oe), .rd_word(rd_word),
		.stall_len(stall_len), .ext_data_in(ext_data_in), .external_wait_n(external_wait_n), .wr_seen(wr_seen));

	task finish_test;
		if (err_total == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		@(posedge hclk);
	endtask

	task cfg(input int cs, input logic [31:0] s, input logic [31:0] p, input logic [31:0] c, input logic [31:0] m);
		ahb(1'b1, 32'(16 * cs), s);
		ahb(1'b1, 32'(16 * cs + 4), p);
		ahb(1'b1, 32'(16 * cs + 8), c);
		ahb(1'b1, 32'(16 * cs + 12), m);
	endtask

	function logic [31:0] md(input logic [1:0] wt, input logic byte_access_kind, input logic [1:0] bus_width_sel, input logic [3:0] tdf,
		input logic pm, input logic [1:0] ps, input logic rdm);
		md = {2'h0, ps, 3'h0, pm, 3'h0, 1'b0, tdf, 2'h0, bus_width_sel, 3'h0, byte_access_kind, 2'h0, wt, 2'h0, 1'b1, rdm};
	endfunction

	task acc(input logic [2:0] cs, input logic w, input logic [25:0] a, input logic [3:0] be);
		acc_req <= 1'b1;
		acc_cs <= cs;
		acc_write <= w;
		acc_addr <= a;
		acc_be <= be;
		acc_wdata <= ~rd_word;
		lat = 0;
		bws_low = 4'h0;
		bs_low = 4'h0;
		ws_low = 1'b0;
		busy_n = 0;
		do begin
			@(negedge hclk);
			lat++;
			bws_low |= ~bws_n;
			bs_low |= ~bs_n;
			ws_low |= ~write_strobe_n;
		end while (acc_done !== 1'b1);
		q = acc_rdata;
		@(posedge hclk);
		acc_req <= 1'b0;
		@(posedge hclk);
	endtask

	always @(negedge hclk) begin
		if (ext_bus_busy === 1'b1)
			busy_n++;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			finish_test();
		end
	end

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		for (int c = 0; c < 8; c += 7) begin
			for (int o = 0; o < 4; o++) begin
				ahb(1'b0, 32'(16 * c + 4 * o), 32'h0);
				chk(q, rstv[o]);
				chk(hresp, 0);
			end
		end
		for (int o = 0; o < 4; o++)
			ahb(1'b1, 32'(16 + 4 * o), 32'hffffffff);
		for (int o = 0; o < 4; o++) begin
			ahb(1'b0, 32'(16 + 4 * o), 32'h0);
			chk(q, mskv[o]);
		end
		ahb(1'b1, 32'h80, 32'hffffffff);
		ahb(1'b0, 32'h80, 32'h0);
		chk(q, 32'h0);
		cfg(2, 32'h01010101, 32'h04040404, 32'h00080008, md(0, 0, 2, 0, 0, 0, 1));
		acc(3'h2, 1'b1, 26'h0, 4'hf);
		lb = lat;
		chk(wr_seen, ~rd_word);
		acc(3'h2, 1'b0, 26'h0, 4'hf);
		la = lat;
		chk(q, rd_word);
		ahb(1'b1, 32'h28, 32'h0008008a);
		acc(3'h2, 1'b1, 26'h0, 4'hf);
		chk(lat, lb);
		ahb(1'b1, 32'h2c, md(0, 0, 2, 0, 0, 0, 1));
		acc(3'h2, 1'b1, 26'h0, 4'hf);
		chk(lat, lb + 258);
		cfg(2, 32'h01010101, 32'h04040404, 32'h008a0008, md(0, 0, 2, 0, 0, 0, 1));
		acc(3'h2, 1'b0, 26'h0, 4'hf);
		chk(lat, la + 258);
		ahb(1'b1, 32'h28, 32'h00080008);
		for (int w = 0; w < 3; w++) begin
			ahb(1'b1, 32'h2c, md(0, 0, w, 0, 0, 0, 1));
			acc(3'h2, 1'b0, 26'h0, 4'hf);
			chk(q, rd_word & wmsk[w]);
		end
		for (int b = 0; b < 2; b++) begin
			ahb(1'b1, 32'h2c, md(0, b, 2, 0, 0, 0, 1));
			acc(3'h2, 1'b1, 26'h0, 4'h5);
			chk(bws_low, b ? 4'h5 : 4'h0);
			chk({ws_low, bs_low}, b ? 5'h00 : 5'h15);
		end
		ahb(1'b1, 32'h2c, md(0, 1, 0, 0, 0, 0, 1));
		acc(3'h2, 1'b1, 26'h0, 4'h1);
		chk({ws_low, bws_low, bs_low}, 9'h100);
		for (int r = 1; r >= 0; r--) begin
			cfg(2, 32'h01010101, 32'h06020404, 32'h00080008, md(0, 0, 2, 0, 0, 0, r));
			acc(3'h2, 1'b0, 26'h0, 4'hf);
			chk(q, r ? rd_word : ~rd_word);
		end
		cfg(2, 32'h01010101, 32'h04040404, 32'h00080008, md(0, 0, 2, 0, 0, 0, 1));
		stall_len <= 4'h6;
		for (int w = 0; w < 4; w++) begin
			ahb(1'b1, 32'h2c, md(w, 0, 2, 0, 0, 0, 1));
			acc(3'h2, 1'b1, 26'h0, 4'hf);
			if (w == 3)
				chk(lat, lb + 5);
			else
				chk(lat, lb + (w == 2 ? 6 : 0));
		end
		stall_len <= 4'h0;
		for (int t = 0; t < 3; t++) begin
			ahb(1'b1, 32'h2c, md(0, 0, 2, tdfs[t], 0, 0, 1));
			acc(3'h2, 1'b0, 26'h0, 4'hf);
			repeat (20) @(posedge hclk);
			chk(busy_n, tdfs[t] + 1);
		end
		for (int p = 0; p < 2; p++) begin
			cfg(3, 32'h0, 32'h06020602, 32'h00080008, md(0, 0, 2, 0, 1, p, 1));
			acc(3'h3, 1'b0, 26'(256 << p), 4'hf);
			acc(3'h3, 1'b0, 26'((256 << p) + 4), 4'hf);
			la = lat;
			chk(q, rd_word);
			acc(3'h3, 1'b0, 26'((256 << p) + 8), 4'hf);
			chk(lat, la + (p ? 4 : 0));
			chk(ext_addr, (256 << p) + 8);
		end
		finish_test();
	end
endmodule // tb_top
